// ---- core/cbf_defines.vh ----
// Notes on behaviour
// - Each mask input picks a source by 4-bit code; 0-5 PWM, 14-15 fault.
// - Level select set blanks low comparator level; clear blanks high level.
// - Enable bits put true mask C, B or A on the OR gate.
// - Enable bits put inverted mask C, B or A on the OR gate.
// - Enable bits put true mask C, B or A on the AND gate.
// - Enable bits put inverted mask C, B or A on the AND gate.
// - Inverted AND result feeds OR gate when its enable is set.
// - True AND result feeds OR gate when its enable is set.
// - Filter enable inserts the filter; clear bypasses it.
// - Three-bit field picks filter clock source; code 3 reserved.
// - Divider field divides filter clock by two to the field value.
// - Filter register bits 15 to 7 read zero and ignore writes.
`ifndef CBF_DEFINES_VH
`define CBF_DEFINES_VH
// ----------------------------------------
// Register map
// ----------------------------------------
`define CBF_ADDR_MASK_SRC      2'h0
`define CBF_ADDR_MASK_GATING   2'h1
`define CBF_ADDR_FILTER        2'h2
`define CBF_ADDR_STATUS        2'h3
`define CBF_RESET_VALUE        16'h0000
// ----------------------------------------
// Gating control field positions
// ----------------------------------------
`define CBF_BLANK_LEVEL_SEL    15
`define CBF_OR_IN_C_EN         13
`define CBF_OR_IN_C_INV_EN     12
`define CBF_OR_IN_B_EN         11
`define CBF_OR_IN_B_INV_EN     10
`define CBF_OR_IN_A_EN         9
`define CBF_OR_IN_A_INV_EN     8
`define CBF_AND_OUT_INV_EN     7
`define CBF_AND_OUT_EN         6
`define CBF_AND_IN_C_EN        5
`define CBF_AND_IN_C_INV_EN    4
`define CBF_AND_IN_B_EN        3
`define CBF_AND_IN_B_INV_EN    2
`define CBF_AND_IN_A_EN        1
`define CBF_AND_IN_A_INV_EN    0
`define CBF_GATING_MASK        16'hBFFF
// ----------------------------------------
// Filter control field positions
// ----------------------------------------
`define CBF_FILTER_EN          3
`define CBF_FILTER_CLK_DIV_LSB 0
`define CBF_FILTER_CLK_SEL_LSB 4
`define CBF_FILTER_MASK        16'h007F
`define CBF_SRC_MASK           16'h0FFF
`define CBF_FILTER_SAMPLES     2'h3
`endif

// ---- core/cbf_mask_mux.v ----
`timescale 1ns/1ps
`default_nettype none
module cbf_mask_mux (
	input  wire       ref_clk,
	input  wire       rst_n,
	input  wire       clk_en,
	input  wire [3:0] sel,
	input  wire [5:0] pwm_outs,
	input  wire       fault_in_two,
	input  wire       fault_in_four,
	output reg        mask_reg
);
	reg mask_next;
	// Source decode, reserved codes give low
	always @* begin
		case (sel)
			4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5: mask_next = pwm_outs[sel[2:0]];
			4'hE: mask_next = fault_in_two;
			4'hF: mask_next = fault_in_four;
			default: mask_next = 1'b0;
		endcase
	end
	// Registered mask level
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_reg <= 1'b0;
		end else if (clk_en) begin
			mask_reg <= mask_next;
		end
	end
endmodule // cbf_mask_mux
`default_nettype wire

// ---- core/cbf_digital_filter.v ----
`include "cbf_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module cbf_digital_filter (
	input  wire ref_clk,
	input  wire rst_n,
	input  wire clk_en,
	input  wire sample_tick,
	input  wire din,
	output reg  dout_reg
);
	reg [1:0] count_reg;
	reg       last_reg;
	// Counts equal samples, updates after three
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			count_reg <= 2'h0;
			last_reg  <= 1'b0;
			dout_reg  <= 1'b0;
		end else if (clk_en && sample_tick) begin
			last_reg <= din;
			if (din != last_reg) begin
				count_reg <= 2'h1;
			end else if (count_reg != `CBF_FILTER_SAMPLES) begin
				count_reg <= count_reg + 2'h1;
				if (count_reg == 2'h2) begin
					dout_reg <= din;
				end
			end
		end
	end
endmodule // cbf_digital_filter
`default_nettype wire

// ---- core/cbf_blanking_filter.v ----
`include "cbf_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module cbf_blanking_filter (
	input  wire        ref_clk,
	input  wire        rst_n,
	input  wire        clk_en,
	input  wire [1:0]  reg_addr,
	input  wire [15:0] reg_wdata,
	input  wire        reg_write,
	input  wire        reg_read,
	output reg  [15:0] reg_rdata,
	input  wire        comp_in,
	input  wire [5:0]  pwm_outs,
	input  wire        fault_in_two,
	input  wire        fault_in_four,
	input  wire        periph_clock,
	input  wire        osc_clock,
	input  wire        pwm_sync_out,
	input  wire        timer2_clock,
	input  wire        timer3_clock,
	input  wire        timer4_clock,
	input  wire        timer5_clock,
	output reg         comp_out_reg,
	output reg         blank_reg
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg  [15:0] mask_src_reg;
	reg  [15:0] mask_gating_ctrl_reg;
	reg  [15:0] digital_filter_ctrl_reg;
	reg  [15:0] rdata_next;
	reg  [6:0]  div_cnt_reg;
	reg         fclk_sync_reg;
	reg         fclk_prev_reg;
	reg         tick_reg;
	reg         src_clk;
	reg         or_out;
	reg         and_out;
	reg         blanked;
	wire        mask_in_a;
	wire        mask_in_b;
	wire        mask_in_c;
	wire        filt_out;
	wire [2:0]  filter_clk_sel;
	wire [2:0]  filter_clk_div;
	wire        filter_en;
	wire        fclk_rise;

	// Bit test helper used by gating logic
	function gbit;
		input [15:0] r;
		input integer pos;
		begin
			gbit = r[pos];
		end
	endfunction

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_src_reg            <= `CBF_RESET_VALUE;
			mask_gating_ctrl_reg    <= `CBF_RESET_VALUE;
			digital_filter_ctrl_reg <= `CBF_RESET_VALUE;
		end else if (clk_en && reg_write) begin
			case (reg_addr)
				`CBF_ADDR_MASK_SRC: mask_src_reg <= reg_wdata & `CBF_SRC_MASK;
				`CBF_ADDR_MASK_GATING: mask_gating_ctrl_reg <= reg_wdata & `CBF_GATING_MASK;
				`CBF_ADDR_FILTER: digital_filter_ctrl_reg <= reg_wdata & `CBF_FILTER_MASK;
				default: ;
			endcase
		end
	end

	// Read mux, status shows live outputs
	always @* begin
		case (reg_addr)
			`CBF_ADDR_MASK_SRC:    rdata_next = mask_src_reg;
			`CBF_ADDR_MASK_GATING: rdata_next = mask_gating_ctrl_reg;
			`CBF_ADDR_FILTER:      rdata_next = digital_filter_ctrl_reg;
			`CBF_ADDR_STATUS:      rdata_next = {13'h0000, mask_in_c, blank_reg, comp_out_reg};
			default:               rdata_next = 16'h0000;
		endcase
	end

	// Read data one cycle after strobe
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 16'h0000;
		end else if (clk_en) begin
			reg_rdata <= reg_read ? rdata_next : 16'h0000;
		end
	end

	// ----------------------------------------
	// Mask sources
	// ----------------------------------------
	cbf_mask_mux u_mask_a (
		.ref_clk       (ref_clk),
		.rst_n         (rst_n),
		.clk_en        (clk_en),
		.sel           (mask_src_reg[3:0]),
		.pwm_outs      (pwm_outs),
		.fault_in_two  (fault_in_two),
		.fault_in_four (fault_in_four),
		.mask_reg      (mask_in_a)
	);
	cbf_mask_mux u_mask_b (
		.ref_clk       (ref_clk),
		.rst_n         (rst_n),
		.clk_en        (clk_en),
		.sel           (mask_src_reg[7:4]),
		.pwm_outs      (pwm_outs),
		.fault_in_two  (fault_in_two),
		.fault_in_four (fault_in_four),
		.mask_reg      (mask_in_b)
	);
	cbf_mask_mux u_mask_c (
		.ref_clk       (ref_clk),
		.rst_n         (rst_n),
		.clk_en        (clk_en),
		.sel           (mask_src_reg[11:8]),
		.pwm_outs      (pwm_outs),
		.fault_in_two  (fault_in_two),
		.fault_in_four (fault_in_four),
		.mask_reg      (mask_in_c)
	);

	// ----------------------------------------
	// Gating network
	// ----------------------------------------
	// AND gate; no input enabled gives low
	always @* begin
		and_out = (gbit(mask_gating_ctrl_reg, `CBF_AND_IN_A_EN)
			| gbit(mask_gating_ctrl_reg, `CBF_AND_IN_A_INV_EN)
			| gbit(mask_gating_ctrl_reg, `CBF_AND_IN_B_EN)
			| gbit(mask_gating_ctrl_reg, `CBF_AND_IN_B_INV_EN)
			| gbit(mask_gating_ctrl_reg, `CBF_AND_IN_C_EN)
			| gbit(mask_gating_ctrl_reg, `CBF_AND_IN_C_INV_EN))
			& (mask_in_a | ~gbit(mask_gating_ctrl_reg, `CBF_AND_IN_A_EN))
			& (~mask_in_a | ~gbit(mask_gating_ctrl_reg, `CBF_AND_IN_A_INV_EN))
			& (mask_in_b | ~gbit(mask_gating_ctrl_reg, `CBF_AND_IN_B_EN))
			& (~mask_in_b | ~gbit(mask_gating_ctrl_reg, `CBF_AND_IN_B_INV_EN))
			& (mask_in_c | ~gbit(mask_gating_ctrl_reg, `CBF_AND_IN_C_EN))
			& (~mask_in_c | ~gbit(mask_gating_ctrl_reg, `CBF_AND_IN_C_INV_EN));
	end

	// OR gate forms the blanking signal
	always @* begin
		or_out = (mask_in_a & gbit(mask_gating_ctrl_reg, `CBF_OR_IN_A_EN))
			| (~mask_in_a & gbit(mask_gating_ctrl_reg, `CBF_OR_IN_A_INV_EN))
			| (mask_in_b & gbit(mask_gating_ctrl_reg, `CBF_OR_IN_B_EN))
			| (~mask_in_b & gbit(mask_gating_ctrl_reg, `CBF_OR_IN_B_INV_EN))
			| (mask_in_c & gbit(mask_gating_ctrl_reg, `CBF_OR_IN_C_EN))
			| (~mask_in_c & gbit(mask_gating_ctrl_reg, `CBF_OR_IN_C_INV_EN))
			| (and_out & gbit(mask_gating_ctrl_reg, `CBF_AND_OUT_EN))
			| (~and_out & gbit(mask_gating_ctrl_reg, `CBF_AND_OUT_INV_EN));
	end

	// Blanking holds last value when selected level appears
	always @* begin
		if (blank_reg && (comp_in == ~mask_gating_ctrl_reg[`CBF_BLANK_LEVEL_SEL])) begin
			blanked = comp_out_reg;
		end else begin
			blanked = comp_in;
		end
	end

	// ----------------------------------------
	// Filter clock select and divide
	// ----------------------------------------
	assign filter_clk_sel = digital_filter_ctrl_reg[`CBF_FILTER_CLK_SEL_LSB +: 3];
	assign filter_clk_div = digital_filter_ctrl_reg[`CBF_FILTER_CLK_DIV_LSB +: 3];
	assign filter_en      = digital_filter_ctrl_reg[`CBF_FILTER_EN];

	// Source pick, reserved code gives no clock
	always @* begin
		case (filter_clk_sel)
			3'h0: src_clk = periph_clock;
			3'h1: src_clk = osc_clock;
			3'h2: src_clk = pwm_sync_out;
			3'h4: src_clk = timer2_clock;
			3'h5: src_clk = timer3_clock;
			3'h6: src_clk = timer4_clock;
			3'h7: src_clk = timer5_clock;
			default: src_clk = 1'b0;
		endcase
	end

	assign fclk_rise = fclk_sync_reg & ~fclk_prev_reg;

	// Edge detect and power-of-two divide
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			fclk_sync_reg <= 1'b0;
			fclk_prev_reg <= 1'b0;
			div_cnt_reg   <= 7'h00;
			tick_reg      <= 1'b0;
		end else if (clk_en) begin
			fclk_sync_reg <= src_clk;
			fclk_prev_reg <= fclk_sync_reg;
			tick_reg      <= 1'b0;
			if (fclk_rise) begin
				if (div_cnt_reg >= ((7'h01 << filter_clk_div) - 7'h01)) begin
					div_cnt_reg <= 7'h00;
					tick_reg    <= 1'b1;
				end else begin
					div_cnt_reg <= div_cnt_reg + 7'h01;
				end
			end
		end
	end

	cbf_digital_filter u_filter (
		.ref_clk     (ref_clk),
		.rst_n       (rst_n),
		.clk_en      (clk_en),
		.sample_tick (tick_reg),
		.din         (blanked),
		.dout_reg    (filt_out)
	);

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			blank_reg    <= 1'b0;
			comp_out_reg <= 1'b0;
		end else if (clk_en) begin
			blank_reg    <= or_out;
			comp_out_reg <= filter_en ? filt_out : blanked;
		end
	end
endmodule // cbf_blanking_filter
`default_nettype wire

// ---- verification/cbf_blanking_filter_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module cbf_blanking_filter_asserts (
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic        clk_en,
	input wire logic [1:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_write,
	input wire logic        reg_read,
	input wire logic [15:0] reg_rdata,
	input wire logic        comp_in,
	input wire logic        comp_out_reg,
	input wire logic        blank_reg
);
	logic [15:0] gat_sh;
	logic [15:0] flt_sh;
	logic        rd_g;
	logic        rd_f;
	// Shadow control words and read markers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			gat_sh <= 16'h0000;
			flt_sh <= 16'h0000;
			rd_g <= 1'b0;
			rd_f <= 1'b0;
		end else begin
			rd_g <= clk_en && reg_read && reg_addr == 2'h1;
			rd_f <= clk_en && reg_read && reg_addr == 2'h2;
			if (clk_en && reg_write && reg_addr == 2'h1) gat_sh <= reg_wdata & 16'hBFFF;
			if (clk_en && reg_write && reg_addr == 2'h2) flt_sh <= reg_wdata & 16'h007F;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_gate_readback: assert property (
		rd_g |-> reg_rdata == $past(gat_sh)) else $error("gating readback wrong");
	a_filt_readback: assert property (
		rd_f |-> reg_rdata == $past(flt_sh)) else $error("filter readback wrong");
	a_filt_upper_zero: assert property (
		rd_f |-> reg_rdata[15:7] == 9'h000) else $error("filter upper bits not zero");
	a_no_gate_blank: assert property (
		gat_sh == 16'h0000 && $past(gat_sh) == 16'h0000 |-> !blank_reg)
		else $error("blanking without any gate input");
	a_bypass_pass: assert property (
		clk_en && !flt_sh[3] && (!blank_reg || comp_in == gat_sh[15])
		|=> comp_out_reg == $past(comp_in)) else $error("bypass output wrong");
	a_blank_hold: assert property (
		clk_en && !flt_sh[3] && blank_reg && comp_in != gat_sh[15] |=> $stable(comp_out_reg))
		else $error("blocked level passed");
	a_resv_clk_hold: assert property (
		flt_sh[6:3] == 4'h7 && $past(flt_sh, 4) == flt_sh |=> $stable(comp_out_reg))
		else $error("reserved filter clock ticked");
	a_filt_min_gap: assert property (
		flt_sh[3] && $past(flt_sh, 4) == flt_sh && $changed(comp_out_reg)
		|=> $stable(comp_out_reg) [*2]) else $error("filter output changed too soon");
	cover property (rd_g);
	cover property (flt_sh[3] && $changed(comp_out_reg));
	cover property (blank_reg && comp_in != gat_sh[15]);
endmodule // cbf_blanking_filter_asserts
bind cbf_blanking_filter cbf_blanking_filter_asserts u_chk (.ref_clk, .rst_n, .clk_en,
	.reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .comp_in, .comp_out_reg,
	.blank_reg);
`default_nettype wire

// ---- verification/cbf_comp_source_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cbf_comp_source_model (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       comp_want,
	input  wire logic [7:0] mask_want,
	output var  logic       comp_in,
	output var  logic [5:0] pwm_outs,
	output var  logic       fault_in_two,
	output var  logic       fault_in_four,
	output var  logic [6:0] clk_srcs
);
	// Source k toggles every 2^k cycles; levels launched after the edge
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_srcs <= 7'h00;
			comp_in <= 1'b0;
			{fault_in_four, fault_in_two, pwm_outs} <= 8'h00;
		end else begin
			clk_srcs <= clk_srcs + 7'h01;
			comp_in <= comp_want;
			{fault_in_four, fault_in_two, pwm_outs} <= mask_want;
		end
	end
endmodule // cbf_comp_source_model
`default_nettype wire

// ---- verification/cbf_blanking_filter_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module cbf_blanking_filter_bench;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        clk_en = 1'b1;
	logic [1:0]  reg_addr = 2'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_write = 1'b0;
	logic        reg_read = 1'b0;
	logic [15:0] reg_rdata;
	logic        comp_want = 1'b0;
	logic [7:0]  mask_want = 8'h00;
	logic        comp_in, fault_in_two, fault_in_four, comp_out_reg, blank_reg;
	logic [5:0]  pwm_outs;
	logic [6:0]  clk_srcs;
	int          n_mismatch = 0;
	int          total_checks = 0;
	localparam logic [15:0] gtab [10] = '{16'h2000, 16'h1000, 16'h0800, 16'h0400, 16'h0200,
		16'h0100, 16'h0040, 16'h0080, 16'h0062, 16'h0095};
	localparam logic [17:0] btab [5] = '{18'h20203, 18'h20201, 18'h00200, 18'h00202, 18'h00003};
	localparam logic [6:0]  ftab [10] = '{7'h08, 7'h0B, 7'h19, 7'h1E, 7'h2A, 7'h48, 7'h5D,
		7'h6C, 7'h78, 7'h0F};
	always #12.5 ref_clk = ~ref_clk;
	cbf_comp_source_model u_src (.ref_clk, .rst_n, .comp_want, .mask_want, .comp_in,
		.pwm_outs, .fault_in_two, .fault_in_four, .clk_srcs);
	cbf_blanking_filter u_dut (.ref_clk, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_write,
		.reg_read, .reg_rdata, .comp_in, .pwm_outs, .fault_in_two, .fault_in_four,
		.periph_clock(clk_srcs[0]), .osc_clock(clk_srcs[1]), .pwm_sync_out(clk_srcs[2]),
		.timer2_clock(clk_srcs[3]), .timer3_clock(clk_srcs[4]), .timer4_clock(clk_srcs[5]),
		.timer5_clock(clk_srcs[6]), .comp_out_reg, .blank_reg);
	task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge ref_clk);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, input logic [15:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge ref_clk);
		reg_read <= 1'b0;
		#1 chk("reg_rdata", reg_rdata, exp);
	endtask
	// Set comparator and mask levels, then let k edges pass
	task automatic drive(input logic c, input logic [7:0] m, input int k);
		@(posedge ref_clk);
		comp_want <= c;
		mask_want <= m;
		repeat (k) @(posedge ref_clk);
		#1;
	endtask
	// Expected blanking from the gating word and {C, B, A}
	function automatic logic blank_of(input logic [15:0] g, input logic [2:0] v);
		logic [5:0] ain;
		logic       and_r;
		ain = {v[2], ~v[2], v[1], ~v[1], v[0], ~v[0]};
		and_r = (g[5:0] != 6'h00) && ((ain | ~g[5:0]) == 6'h3F);
		return |(g[13:6] & {ain, ~and_r, and_r});
	endfunction
	task automatic t_regs;
		rd(2'h2, 16'h0000);
		wr(2'h1, 16'hFFFF);
		wr(2'h2, 16'hFFFF);
		wr(2'h0, 16'hFFFF);
		rd(2'h1, 16'hBFFF);
		rd(2'h2, 16'h007F);
		rd(2'h0, 16'h0FFF);
		wr(2'h2, 16'h0000);
		wr(2'h1, 16'h0000);
		// Clock enable low must freeze the register file
		@(posedge ref_clk);
		clk_en <= 1'b0;
		wr(2'h1, 16'h0200);
		@(posedge ref_clk);
		clk_en <= 1'b1;
		rd(2'h1, 16'h0000);
		$display("t_regs done");
	endtask
	task automatic t_src;
		logic [7:0] m;
		wr(2'h1, 16'h2000);
		for (int c = 0; c < 16; c++) begin
			m = (c < 6) ? 8'h01 << c : (c == 14) ? 8'h40 : (c == 15) ? 8'h80 : 8'h00;
			wr(2'h0, 16'(c) << 8);
			drive(1'b0, m, 4);
			chk("blank_reg", 16'(blank_reg), 16'(m != 8'h00));
			rd(2'h3, (m != 8'h00) ? 16'h0006 : 16'h0000);
			drive(1'b0, ~m, 4);
			chk("blank_reg", 16'(blank_reg), 16'h0000);
		end
		$display("t_src done");
	endtask
	task automatic t_gate;
		wr(2'h0, 16'h0210);
		foreach (gtab[i]) begin
			wr(2'h1, gtab[i]);
			for (int v = 0; v < 8; v++) begin
				drive(1'b0, 8'(v), 4);
				chk("blank_reg", 16'(blank_reg), 16'(blank_of(gtab[i], 3'(v))));
			end
		end
		foreach (btab[i]) begin
			wr(2'h1, btab[i][17:2]);
			drive(btab[i][1], 8'h00, 4);
			chk("comp_out_reg", 16'(comp_out_reg), 16'(btab[i][0]));
		end
		$display("t_gate done");
	endtask
	task automatic t_filt;
		int per;
		int n;
		wr(2'h1, 16'h0000);
		drive(1'b0, 8'h00, 2);
		foreach (ftab[i]) begin
			per = (2 << (ftab[i][6:4] - (ftab[i][6:4] > 3'h3 ? 3'h1 : 3'h0))) << ftab[i][2:0];
			wr(2'h2, 16'(ftab[i]));
			repeat (3 * per + 8) @(posedge ref_clk);
			comp_want <= 1'b1;
			n = 0;
			while (comp_out_reg !== 1'b1 && n < 4 * per + 20) begin
				@(negedge ref_clk);
				n++;
			end
			chk("filter delay low", 16'(n >= 2 * per), 16'h0001);
			chk("filter delay high", 16'(n <= 3 * per + 8), 16'h0001);
			@(posedge ref_clk);
			comp_want <= 1'b0;
		end
		wr(2'h2, 16'h000A);
		drive(1'b0, 8'h00, 40);
		drive(1'b1, 8'h00, 2);
		drive(1'b0, 8'h00, 40);
		chk("comp_out_reg", 16'(comp_out_reg), 16'h0000);
		wr(2'h2, 16'h0038);
		drive(1'b1, 8'h00, 300);
		chk("comp_out_reg", 16'(comp_out_reg), 16'h0000);
		wr(2'h2, 16'h0000);
		drive(1'b1, 8'h00, 4);
		chk("comp_out_reg", 16'(comp_out_reg), 16'h0001);
		$display("t_filt done");
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_regs;
		t_src;
		t_gate;
		t_filt;
		stop_test;
	end
	// Watchdog
	initial begin
		#1500000;
		n_mismatch++;
		stop_test;
	end
endmodule // cbf_blanking_filter_bench
`default_nettype wire
